// [bench/stom_safety_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module stom_safety_ctrl (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // commands from the bench
    input  wire logic       off_req,
    input  wire logic       one_only,
    input  wire logic [3:0] skew,
    // torque-off channels
    output logic            ch_a,
    output logic            ch_b
);
    logic [3:0] cnt_reg;

    // ==================================================================
    // channel drive
    // skew lets b trail a; one_only is a commanded wiring fault
    always_ff @(posedge clk) begin
        if (srst) begin
            ch_a    <= 1'b0;
            ch_b    <= 1'b0;
            cnt_reg <= 4'h0;
        end else if (off_req) begin
            ch_a <= 1'b0;
            if (!one_only && cnt_reg == skew) begin
                ch_b <= 1'b0;
            end else if (cnt_reg != skew) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end else begin
            ch_a    <= 1'b1;
            ch_b    <= 1'b1;
            cnt_reg <= 4'h0;
        end
    end
endmodule : stom_safety_ctrl
`default_nettype wire

// [bench/stom_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module stom_top_monitor
    import stom_pkg::*;
#(
    parameter int WIN_W = 16
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // channels, supervision, operator
    input  wire logic                        safe_off_channel_a,
    input  wire logic                        safe_off_channel_b,
    input  wire logic                        supply_fault,
    input  wire logic                        input_circuit_fault,
    input  wire logic                        blocking_stage_fault,
    input  wire logic                        operator_reset,
    // outputs
    input  wire logic                        pwm_enable,
    input  var  stom_pkg::stom_exit_t        disp_exit_mode,
    input  var  stom_pkg::stom_state_t       disp_state,
    input  var  stom_pkg::stom_fault_t       disp_fault,
    // register port
    input  wire logic [stom_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [stom_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr
);
    logic             diag;
    logic             both_hi;
    logic             mism;
    logic             man_rst;
    logic [WIN_W-1:0] win_reg;
    logic [WIN_W:0]   run_reg;

    assign diag    = supply_fault | input_circuit_fault | blocking_stage_fault;
    assign both_hi = safe_off_channel_a & safe_off_channel_b;
    assign mism    = safe_off_channel_a ^ safe_off_channel_b;
    assign man_rst = operator_reset | (reg_wr && reg_addr == OFS_CTRL
                     && reg_wdata[CTRL_MAN_RESET_BIT]);

    // ==================================================================
    // mirror of the window and length of the current mismatch
    always_ff @(posedge clk) begin
        if (srst) begin
            win_reg <= WINDOW_RST[WIN_W-1:0];
        end else if (reg_wr && reg_addr == OFS_WINDOW) begin
            win_reg <= reg_wdata[WIN_W-1:0];
        end
    end
    always_ff @(posedge clk) begin
        if (srst || !mism) begin
            run_reg <= '0;
        end else begin
            run_reg <= run_reg + 1'b1;
        end
    end

    // ==================================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_pwm_block: assert property (
        (!both_hi || diag) |=> !pwm_enable)
        else $error("pwm still enabled after channel drop");
    chk_pwm_cause: assert property (
        pwm_enable |-> $past(both_hi && !diag))
        else $error("pwm enabled without both channels high");
    chk_request_code: assert property (
        (!safe_off_channel_a && !safe_off_channel_b)[*2]
        |-> disp_fault != FLT_NONE)
        else $error("no code shown with both channels low");
    chk_incons_trip: assert property (
        (mism && run_reg == {1'b0, win_reg} && !diag)
        ##1 (!both_hi && !diag)[*2] |=> disp_fault == FLT_INCONS)
        else $error("mismatch beyond window did not trip");
    chk_supply_code: assert property (
        supply_fault |-> ##2 disp_fault inside {FLT_SUPPLY, FLT_IN_CIRC,
        FLT_BLOCK})
        else $error("supply fault code missing");
    chk_circuit_code: assert property (
        input_circuit_fault |-> ##2 disp_fault inside {FLT_IN_CIRC,
        FLT_BLOCK})
        else $error("input circuit fault code missing");
    chk_block_code: assert property (
        blocking_stage_fault |-> ##2 disp_fault == FLT_BLOCK)
        else $error("blocking stage fault code missing");
    chk_auto_exit: assert property (
        (disp_exit_mode == EXIT_AUTO && disp_state == ST_SAFE && both_hi
        && !diag) |=> (disp_state == ST_RUN && pwm_enable))
        else $error("automatic exit did not happen");
    chk_manual_hold: assert property (
        (disp_exit_mode == EXIT_MANUAL && disp_state != ST_RUN && !man_rst)
        |=> disp_state != ST_RUN)
        else $error("manual mode left safe state without reset");

    cov_incons: cover property (disp_fault == FLT_INCONS);
    cov_auto_run: cover property ($rose(pwm_enable)
        && disp_exit_mode == EXIT_AUTO);
    cov_block: cover property ($fell(pwm_enable));
endmodule : stom_top_monitor

bind stom_top stom_top_monitor #(.WIN_W(WIN_W)) u_monitor (
    .clk(clk), .srst(srst),
    .safe_off_channel_a(safe_off_channel_a),
    .safe_off_channel_b(safe_off_channel_b),
    .supply_fault(supply_fault), .input_circuit_fault(input_circuit_fault),
    .blocking_stage_fault(blocking_stage_fault),
    .operator_reset(operator_reset), .pwm_enable(pwm_enable),
    .disp_exit_mode(disp_exit_mode), .disp_state(disp_state),
    .disp_fault(disp_fault), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr)
);
`default_nettype wire

// [bench/stom_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module stom_top_tb;
    import stom_pkg::*;

    // ==================================================================
    // bench signals
    localparam logic [15:0] WIN = 16'h0004;
    logic              clk       = 1'b0;
    logic              srst      = 1'b1;
    logic              off_req   = 1'b1;
    logic              one_only  = 1'b0;
    logic [3:0]        skew      = 4'h0;
    logic [2:0]        diag      = 3'h0;
    logic              op_rst    = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              ch_a;
    logic              ch_b;
    logic              pwm_enable;
    logic              irq;
    stom_exit_t        disp_exit_mode;
    stom_state_t       disp_state;
    stom_fault_t       disp_fault;
    int                failures   = 0;
    int                n_compared = 0;
    stom_fault_t       codes[3]   = '{FLT_SUPPLY, FLT_IN_CIRC, FLT_BLOCK};

    always #5 clk = ~clk;

    stom_safety_ctrl u_ctrl (
        .clk(clk), .srst(srst), .off_req(off_req), .one_only(one_only),
        .skew(skew), .ch_a(ch_a), .ch_b(ch_b)
    );

    stom_top #(.PWM_BLOCK_CYC(4)) uut (
        .clk(clk), .srst(srst),
        .safe_off_channel_a(ch_a), .safe_off_channel_b(ch_b),
        .supply_fault(diag[0]), .input_circuit_fault(diag[1]),
        .blocking_stage_fault(diag[2]), .operator_reset(op_rst),
        .pwm_enable(pwm_enable), .disp_exit_mode(disp_exit_mode),
        .disp_state(disp_state), .disp_fault(disp_fault),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
    );

    // ==================================================================
    // tasks
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] m,
                      input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata & m, exp);
    endtask : rd

    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ==================================================================
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #(20_000 * 10);
        failures++;
        test_done();
    end

    // ==================================================================
    // sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        tick(3);
        check("state", disp_state, ST_SAFE);
        check("fault", disp_fault, FLT_STO_REQ);
        check("pwm", pwm_enable, 1'b0);
        rd(OFS_CTRL, 16'hffff, CTRL_RST, "ctrl");
        rd(OFS_MASK, 16'hffff, MASK_RST, "mask");
        rd(OFS_WINDOW, 16'hffff, WINDOW_RST, "window");
        rd(4'hf, 16'hffff, 16'h0000, "unmapped");
        wr(OFS_STATUS, 16'hffff);
        wr(OFS_WINDOW, WIN);
        rd(OFS_WINDOW, 16'hffff, WIN, "window");
        wr(OFS_MASK, 16'h003f);
        // manual mode: healthy channels only arm the exit
        @(posedge clk) off_req <= 1'b0;
        tick(4);
        check("state", disp_state, ST_ARMED);
        check("pwm", pwm_enable, 1'b0);
        rd(OFS_STATUS, 16'h001f, 16'h000f, "status");
        @(posedge clk) op_rst <= 1'b1;
        @(posedge clk) op_rst <= 1'b0;
        tick(3);
        check("state", disp_state, ST_RUN);
        check("pwm", pwm_enable, 1'b1);
        check("fault", disp_fault, FLT_NONE);
        check("irq", irq, 1'b1);
        rd(OFS_EVENT, 16'h0020, 16'h0020, "event");
        wr(OFS_EVENT, 16'h003f);
        tick(2);
        check("irq", irq, 1'b0);
        wr(OFS_MASK, 16'h0000);
        // skew equal to the window must not trip
        @(posedge clk);
        skew    <= WIN[3:0];
        off_req <= 1'b1;
        tick(3);
        check("pwm", pwm_enable, 1'b0);
        tick(int'(WIN) + 6);
        check("fault", disp_fault, FLT_STO_REQ);
        check("irq", irq, 1'b0);
        wr(OFS_MASK, 16'h0001);
        tick(2);
        check("irq", irq, 1'b1);
        wr(OFS_EVENT, 16'h0001);
        tick(2);
        check("irq", irq, 1'b0);
        @(posedge clk) off_req <= 1'b0;
        tick(4);
        wr(OFS_CTRL, 16'h0002);
        tick(2);
        check("state", disp_state, ST_RUN);
        rd(OFS_CTRL, 16'hffff, 16'h0000, "ctrl");
        // one channel stuck high: inconsistency, reset refused
        @(posedge clk);
        one_only <= 1'b1;
        off_req  <= 1'b1;
        tick(int'(WIN) + 8);
        check("fault", disp_fault, FLT_INCONS);
        @(posedge clk) op_rst <= 1'b1;
        @(posedge clk) op_rst <= 1'b0;
        tick(3);
        check("state", disp_state, ST_SAFE);
        // automatic mode exits on healthy channels alone
        wr(OFS_CTRL, 16'h0001);
        @(posedge clk);
        one_only <= 1'b0;
        off_req  <= 1'b0;
        tick(4);
        check("state", disp_state, ST_RUN);
        check("pwm", pwm_enable, 1'b1);
        check("mode", disp_exit_mode, EXIT_AUTO);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) diag <= 3'h1 << i;
            tick(3);
            check("fault", disp_fault, codes[i]);
            check("pwm", pwm_enable, 1'b0);
            @(posedge clk) diag <= 3'h0;
            tick(3);
            check("pwm", pwm_enable, 1'b1);
        end
        rd(OFS_STATUS, 16'hffff, 16'h0013, "status");
        rd(OFS_EVENT, 16'h001e, 16'h001e, "event");
        test_done();
    end
endmodule : stom_top_tb
`default_nettype wire

// [design/stom_chk_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface stom_chk_if #(
    parameter int WIN_W = 16
);
    logic             ch_a;
    logic             ch_b;
    logic [WIN_W-1:0] window;
    logic             incons_evt;
    logic             mismatch;

    modport mon (output ch_a, output ch_b, output window,
                 input incons_evt, input mismatch);
    modport chk (input ch_a, input ch_b, input window,
                 output incons_evt, output mismatch);
endinterface : stom_chk_if
`default_nettype wire

// [design/stom_disc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module stom_disc_chk #(
    parameter int WIN_W = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // channel pair
    stom_chk_if.chk   chk
);
    logic [WIN_W-1:0] count_reg;
    logic             tripped_reg;
    logic             evt_reg;

    assign chk.mismatch   = chk.ch_a ^ chk.ch_b;
    assign chk.incons_evt = evt_reg;

    // ==================================================================
    // discrepancy timer: skew up to the window, equal included, is forgiven
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg   <= '0;
            tripped_reg <= 1'b0;
            evt_reg     <= 1'b0;
        end else if (!chk.mismatch) begin
            count_reg   <= '0;
            tripped_reg <= 1'b0;
            evt_reg     <= 1'b0;
        end else if (!tripped_reg && count_reg >= chk.window) begin
            tripped_reg <= 1'b1;
            evt_reg     <= 1'b1;
        end else begin
            evt_reg <= 1'b0;
            if (!tripped_reg) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end
endmodule : stom_disc_chk
`default_nettype wire

// [design/stom_pkg.sv]
`default_nettype none
package stom_pkg;

    // ==================================================================
    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ==================================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_EVENT  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 4'h4;

    // ==================================================================
    // control register fields
    localparam int CTRL_EXIT_MODE_BIT = 0;
    localparam int CTRL_MAN_RESET_BIT = 1;

    // ==================================================================
    // status register fields
    localparam int STS_CH_A_BIT      = 0;
    localparam int STS_CH_B_BIT      = 1;
    localparam int STS_STATE_LSB     = 2;
    localparam int STS_PWM_BIT       = 4;
    localparam int STS_FAULT_LSB     = 5;

    // ==================================================================
    // event / mask register fields
    localparam int EV_STO_REQ = 0;
    localparam int EV_INCONS  = 1;
    localparam int EV_SUPPLY  = 2;
    localparam int EV_IN_CIRC = 3;
    localparam int EV_BLOCK   = 4;
    localparam int EV_EXIT    = 5;
    localparam int EV_W       = 6;

    // ==================================================================
    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] MASK_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] WINDOW_RST = 16'h03e8;

    // ==================================================================
    // timing
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint PWM_BLOCK_MS  = 20;
    // longest time: rounds down
    localparam longint PWM_BLOCK_CYC_DEF = (PWM_BLOCK_MS * CLK_HZ) / 1000;
    // cycles from a channel edge at the pins to pwm_enable falling
    localparam longint BLOCK_LATENCY = 1;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SAFE  = 2'b01,
        ST_ARMED = 2'b11
    } stom_state_t;

    typedef enum logic [2:0] {
        FLT_NONE    = 3'h0,
        FLT_STO_REQ = 3'h1,
        FLT_INCONS  = 3'h2,
        FLT_SUPPLY  = 3'h3,
        FLT_IN_CIRC = 3'h4,
        FLT_BLOCK   = 3'h5
    } stom_fault_t;

    typedef enum logic {
        EXIT_MANUAL = 1'b0,
        EXIT_AUTO   = 1'b1
    } stom_exit_t;

endpackage : stom_pkg
`default_nettype wire

// [design/stom_top.sv]
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module stom_top
    import stom_pkg::*;
#(
    parameter int     WIN_W         = 16,
    parameter longint PWM_BLOCK_CYC = stom_pkg::PWM_BLOCK_CYC_DEF
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // redundant torque-off channels, high to allow torque
    input  wire logic                        safe_off_channel_a,
    input  wire logic                        safe_off_channel_b,
    // internal supervision and operator
    input  wire logic                        supply_fault,
    input  wire logic                        input_circuit_fault,
    input  wire logic                        blocking_stage_fault,
    input  wire logic                        operator_reset,
    // power stage
    output logic                             pwm_enable,
    // display
    output var stom_pkg::stom_exit_t         disp_exit_mode,
    output var stom_pkg::stom_state_t        disp_state,
    output var stom_pkg::stom_fault_t        disp_fault,
    // register port
    input  wire logic [stom_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [stom_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [stom_pkg::DATA_W-1:0] reg_rdata,
    // interrupt
    output logic                             irq
);
    import stom_pkg::*;

    // ==================================================================
    // elaboration checks
    generate
        if (WIN_W < 1 || WIN_W > DATA_W) begin : g_bad_win
            $error("window width must lie between 1 and the data width");
        end
        if (PWM_BLOCK_CYC < BLOCK_LATENCY) begin : g_bad_block
            $error("blocking deadline shorter than the blocking latency");
        end
    endgenerate

    // ==================================================================
    // declarations
    stom_chk_if #(.WIN_W(WIN_W)) chk_bus ();

    stom_state_t      state_reg;
    stom_state_t      state_next;
    stom_exit_t       exit_mode_reg;
    stom_fault_t      fault_reg;
    stom_fault_t      fault_next;
    logic [WIN_W-1:0] window_reg;
    logic [EV_W-1:0]  event_reg;
    logic [EV_W-1:0]  event_next;
    logic [EV_W-1:0]  event_set;
    logic [EV_W-1:0]  event_clr;
    logic [EV_W-1:0]  mask_reg;
    logic             pwm_reg;
    logic             irq_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic             incons_lat_reg;
    logic             supply_lat_reg;
    logic             in_circ_lat_reg;
    logic             block_lat_reg;
    logic             both_low_prev_reg;
    logic             supply_prev_reg;
    logic             in_circ_prev_reg;
    logic             block_prev_reg;
    logic             both_high;
    logic             both_low;
    logic             diag_any;
    logic             healthy;
    logic             man_reset;
    logic             leave_safe;
    logic             wr_ctrl;
    logic             wr_event;

    // ==================================================================
    // channel decode
    assign both_high = safe_off_channel_a & safe_off_channel_b;
    assign both_low  = ~safe_off_channel_a & ~safe_off_channel_b;
    assign diag_any  = supply_fault | input_circuit_fault
                     | blocking_stage_fault;
    assign healthy   = both_high & ~diag_any;

    assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_event  = reg_wr && (reg_addr == OFS_EVENT);
    // reset may come from the panel pin or from software
    assign man_reset = operator_reset
                     | (wr_ctrl & reg_wdata[CTRL_MAN_RESET_BIT]);

    // ==================================================================
    // discrepancy checker
    assign chk_bus.ch_a   = safe_off_channel_a;
    assign chk_bus.ch_b   = safe_off_channel_b;
    assign chk_bus.window = window_reg;

    stom_disc_chk #(
        .WIN_W (WIN_W)
    ) u_disc_chk (
        .clk  (clk),
        .srst (srst),
        .chk  (chk_bus.chk)
    );

    // ==================================================================
    // safe state sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (!healthy) begin
                    state_next = ST_SAFE;
                end
            end
            ST_SAFE: begin
                if (healthy) begin
                    if (exit_mode_reg == EXIT_AUTO) begin
                        state_next = ST_RUN;
                    end else if (man_reset) begin
                        state_next = ST_RUN;
                    end else begin
                        state_next = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                if (!healthy) begin
                    state_next = ST_SAFE;
                end else if (man_reset
                             || exit_mode_reg == EXIT_AUTO) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_SAFE;
            end
        endcase
    end

    assign leave_safe = (state_reg != ST_RUN) && (state_next == ST_RUN);

    // powers up safe; the drive needs its exit condition once first
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_SAFE;
        end else begin
            state_reg <= state_next;
        end
    end

    // one cycle from a channel drop to blocking, far inside the deadline
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= (state_next == ST_RUN);
        end
    end

    // ==================================================================
    // fault latches: held until the safe state is left
    always_ff @(posedge clk) begin
        if (srst) begin
            incons_lat_reg  <= 1'b0;
            supply_lat_reg  <= 1'b0;
            in_circ_lat_reg <= 1'b0;
            block_lat_reg   <= 1'b0;
        end else begin
            incons_lat_reg  <= chk_bus.incons_evt
                             | (incons_lat_reg & ~leave_safe);
            supply_lat_reg  <= supply_fault
                             | (supply_lat_reg & ~leave_safe);
            in_circ_lat_reg <= input_circuit_fault
                             | (in_circ_lat_reg & ~leave_safe);
            block_lat_reg   <= blocking_stage_fault
                             | (block_lat_reg & ~leave_safe);
        end
    end

    // ==================================================================
    // display: the most serious condition wins
    always_comb begin
        if (block_lat_reg) begin
            fault_next = FLT_BLOCK;
        end else if (in_circ_lat_reg) begin
            fault_next = FLT_IN_CIRC;
        end else if (supply_lat_reg) begin
            fault_next = FLT_SUPPLY;
        end else if (incons_lat_reg) begin
            fault_next = FLT_INCONS;
        end else if (both_low) begin
            fault_next = FLT_STO_REQ;
        end else begin
            fault_next = FLT_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_reg <= FLT_NONE;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // ==================================================================
    // control and window registers
    always_ff @(posedge clk) begin
        if (srst) begin
            exit_mode_reg <= stom_exit_t'(CTRL_RST[CTRL_EXIT_MODE_BIT]);
            window_reg    <= WINDOW_RST[WIN_W-1:0];
            mask_reg      <= MASK_RST[EV_W-1:0];
        end else begin
            if (wr_ctrl) begin
                exit_mode_reg <=
                    stom_exit_t'(reg_wdata[CTRL_EXIT_MODE_BIT]);
            end
            if (reg_wr && reg_addr == OFS_WINDOW) begin
                window_reg <= reg_wdata[WIN_W-1:0];
            end
            if (reg_wr && reg_addr == OFS_MASK) begin
                mask_reg <= reg_wdata[EV_W-1:0];
            end
        end
    end

    // ==================================================================
    // events and interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            both_low_prev_reg <= 1'b0;
            supply_prev_reg   <= 1'b0;
            in_circ_prev_reg  <= 1'b0;
            block_prev_reg    <= 1'b0;
        end else begin
            both_low_prev_reg <= both_low;
            supply_prev_reg   <= supply_fault;
            in_circ_prev_reg  <= input_circuit_fault;
            block_prev_reg    <= blocking_stage_fault;
        end
    end

    always_comb begin
        event_set             = '0;
        event_set[EV_STO_REQ] = both_low & ~both_low_prev_reg;
        event_set[EV_INCONS]  = chk_bus.incons_evt;
        event_set[EV_SUPPLY]  = supply_fault & ~supply_prev_reg;
        event_set[EV_IN_CIRC] = input_circuit_fault & ~in_circ_prev_reg;
        event_set[EV_BLOCK]   = blocking_stage_fault & ~block_prev_reg;
        event_set[EV_EXIT]    = leave_safe;
        event_clr             = wr_event ? reg_wdata[EV_W-1:0] : '0;
        // a new event beats a clear in the same cycle
        event_next            = event_set | (event_reg & ~event_clr);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            event_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            event_reg <= event_next;
            irq_reg   <= |(event_next & mask_reg);
        end
    end

    // ==================================================================
    // register read port: data only in the cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    rdata_next[CTRL_EXIT_MODE_BIT] = exit_mode_reg;
                end
                OFS_STATUS: begin
                    rdata_next[STS_CH_A_BIT] = safe_off_channel_a;
                    rdata_next[STS_CH_B_BIT] = safe_off_channel_b;
                    rdata_next[STS_STATE_LSB +: 2] = state_reg;
                    rdata_next[STS_PWM_BIT] = pwm_reg;
                    rdata_next[STS_FAULT_LSB +: 3] = fault_reg;
                end
                OFS_EVENT: begin
                    rdata_next[EV_W-1:0] = event_reg;
                end
                OFS_MASK: begin
                    rdata_next[EV_W-1:0] = mask_reg;
                end
                OFS_WINDOW: begin
                    rdata_next[WIN_W-1:0] = window_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ==================================================================
    // outputs
    assign pwm_enable     = pwm_reg;
    assign disp_exit_mode = exit_mode_reg;
    assign disp_state     = state_reg;
    assign disp_fault     = fault_reg;
    assign reg_rdata      = rdata_reg;
    assign irq            = irq_reg;

endmodule : stom_top
`default_nettype wire
